// >>> src/sfpc_pkg.sv
/*
  Constants shared by the serial flash pin-control block.
  Assumes a single system clock; pin-side timing is taken from
  sampled pins, and no software register map exists.
*/
package sfpc_pkg;
  // Clock rate of sys_clk in MHz
  localparam int CLK_MHZ = 25;
  // Opcode width in bits
  localparam int OPC_BITS = 8;
  // Address bytes that follow the opcode
  localparam int ADDR_BYTES = 3;
  localparam int ADDR_BITS = ADDR_BYTES * 8;
  // Pages in the main array and the two page sizes
  localparam int PAGE_COUNT = 1024;
  localparam logic [8:0] PAGE_SMALL = 9'h100;
  localparam logic [8:0] PAGE_LARGE = 9'h108;
  // Buffer byte address width
  localparam int BUF_AW = 9;
  // Receive FIFO shape
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 8 + BUF_AW;
  // Sectors with a protection flag
  localparam int SECT_COUNT = 8;
  // Self-timed program or erase time in microseconds
  localparam int OP_TIME_US = 1000;
  localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;
  // Pin vector layout after synchronising
  localparam int PIN_CS = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_SI = 2;
  localparam int PIN_WP = 3;
  localparam int PIN_RST = 4;
  localparam int PIN_COUNT = 5;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OPC = 3'h1,
    ST_ADDR = 3'h2,
    ST_DATA = 3'h3,
    ST_HOLD = 3'h4
  } sfpc_state_type;
endpackage

// >>> src/sfpc_top.sv
/*
  Serial flash pin-control block: SPI framing, bit timing, output
  enable, standby, write-guard gating, reset pin, and a receive FIFO.
  Assumes pins are asynchronous to sys_clk and that sys_clk is well
  above twice the serial clock rate. The user side classifies opcodes.
*/
// Summary of operation
// - Deselected means output released, and standby once no timed run is busy
// - Deselected device ignores serial input entirely
// - Select falling starts, select rising ends operations
// - Standby waits for running program or erase
// - Sample on clock rise, drive on fall
// - Guard low protects all flagged sectors
// - Guard low refuses protection register changes
// - Guarded modify command discarded until deselect
// - Protect-enable and lockdown still run guarded
// - Reset pin aborts and holds sequencer idle
// - 1024 pages of 256 or 264 bytes
// - Program and erase timed internally
// - Opcode byte first, then address bytes
// - Everything shifted most significant bit first
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
// Receive FIFO with valid and ready on both sides
module sfpc_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clear,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  // Storage words
  logic [WIDTH-1:0] mem_reg [DEPTH];
  // Pointers carry one wrap bit
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                      (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];

  // Write side storage
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  // Write pointer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
    end else if (clear) begin
      wr_ptr_reg <= '0;
    end else if (push) begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  // Read pointer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_ptr_reg <= '0;
    end else if (clear) begin
      rd_ptr_reg <= '0;
    end else if (pop) begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////
// Pin-level control of the serial flash
module sfpc_top #(
  parameter int OP_LEN = sfpc_pkg::OP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic si_pin,
  output logic so_out,
  output logic so_oe,
  input wire logic wp_n_pin,
  input wire logic rst_n_pin,
  input wire logic page_264,
  input wire logic [sfpc_pkg::SECT_COUNT-1:0] prot_flags,
  input wire logic sw_prot_en,
  output logic [sfpc_pkg::SECT_COUNT-1:0] sect_locked,
  output logic cmd_valid,
  output logic [sfpc_pkg::OPC_BITS-1:0] cmd_opcode,
  output logic [sfpc_pkg::ADDR_BITS-1:0] cmd_addr,
  input wire logic cmd_is_modify,
  input wire logic cmd_is_spr_write,
  input wire logic cmd_is_exempt,
  input wire logic cmd_is_read,
  output logic cmd_discard,
  output logic op_start,
  output logic busy,
  output logic standby,
  output logic op_abort,
  input wire logic [7:0] tx_byte,
  output logic tx_load,
  output logic [7:0] rx_data,
  output logic [sfpc_pkg::BUF_AW-1:0] rx_addr,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic buf_ready
);
  import sfpc_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Declarations
  logic [PIN_COUNT-1:0] meta_reg;     // First synchroniser stage
  logic [PIN_COUNT-1:0] sync_reg;     // Second synchroniser stage
  logic sck_prev_reg;                 // Clock history for edges
  logic sel_prev_reg;                 // Select history for edges
  logic sel;                          // Device selected
  logic sck_rise;                     // Serial clock rising
  logic sck_fall;                     // Serial clock falling
  logic sel_fall;                     // Select asserted now
  logic sel_rise;                     // Select released now
  logic guard;                        // Write guard asserted
  logic pin_rst;                      // Reset pin asserted
  sfpc_state_type state_reg;          // Sequencer state
  sfpc_state_type state_next;
  logic [4:0] bit_cnt_reg;            // Bits in current field
  logic [OPC_BITS-1:0] opc_reg;       // Captured opcode
  logic [ADDR_BITS-1:0] addr_reg;     // Captured address
  logic [7:0] rx_sh_reg;              // Incoming data byte
  logic [7:0] tx_sh_reg;              // Outgoing data byte
  logic [2:0] tx_cnt_reg;             // Bits sent of current byte
  logic rd_mode_reg;                  // Read data phase active
  logic mod_ok_reg;                   // Accepted modify pending
  logic [BUF_AW-1:0] baddr_reg;       // Buffer byte address
  logic [BUF_AW-1:0] page_size;       // Selected page size
  logic [31:0] op_cnt_reg;            // Self-timed cycle count
  logic addr_done;                    // Last address bit taken
  logic byte_done;                    // Data byte complete
  logic refuse;                       // Guard refuses command
  logic [FIFO_WIDTH-1:0] fifo_in;

  //////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for every pin
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 5'h1B;              // cs_n, sck, wp_n, rst_n high
      sync_reg <= 5'h1B;
    end else begin
      meta_reg <= {rst_n_pin, wp_n_pin, si_pin, sck_pin, cs_n_pin};
      sync_reg <= meta_reg;
    end
  end

  // Edge history of serial clock and select
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_prev_reg <= 1'b0;
      sel_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= sync_reg[PIN_SCK];
      sel_prev_reg <= sel;
    end
  end

  // Decoded pin events
  assign sel = !sync_reg[PIN_CS];
  assign sck_rise = sel && sync_reg[PIN_SCK] && !sck_prev_reg;
  assign sck_fall = sel && !sync_reg[PIN_SCK] && sck_prev_reg;
  assign sel_fall = sel && !sel_prev_reg;
  assign sel_rise = !sel && sel_prev_reg;
  assign guard = !sync_reg[PIN_WP];
  assign pin_rst = !sync_reg[PIN_RST];
  assign op_abort = pin_rst;

  //////////////////////////////////////////////////////////////////////
  // Sector protection outputs, one per sector
  genvar gi;
  generate
    for (gi = 0; gi < SECT_COUNT; gi++) begin : g_sect
      // Guard protects flagged sectors regardless of software
      assign sect_locked[gi] = prot_flags[gi] && (guard || sw_prot_en);
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // Sequencer next state
  assign addr_done = (state_reg == ST_ADDR) && sck_rise &&
                     (bit_cnt_reg == 5'(ADDR_BITS - 1));
  assign byte_done = (state_reg == ST_DATA) && sck_rise &&
                     (bit_cnt_reg == 5'h07);
  // Modify or protection-register writes refused under guard
  assign refuse = guard && !cmd_is_exempt &&
                  (cmd_is_modify || cmd_is_spr_write);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // Only a select falling edge opens a frame
        if (sel_fall) begin
          state_next = ST_OPC;
        end
      end
      ST_OPC: begin
        // Opcode byte comes first
        if (sck_rise && bit_cnt_reg == 5'(OPC_BITS - 1)) begin
          state_next = ST_ADDR;
        end
      end
      ST_ADDR: begin
        // Refused command waits out the frame
        if (addr_done) begin
          state_next = refuse ? ST_HOLD : ST_DATA;
        end
      end
      ST_DATA: begin
        state_next = ST_DATA;
      end
      ST_HOLD: begin
        state_next = ST_HOLD;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // Deselect ends every frame
    if (!sel) begin
      state_next = ST_IDLE;
    end
  end

  // Sequencer state register, held idle by the reset pin
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
    end else if (pin_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Input shifting, most significant bit first on clock rise
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_reg <= 5'h00;
      opc_reg <= '0;
      addr_reg <= '0;
      rx_sh_reg <= 8'h00;
    end else if (pin_rst || state_reg == ST_IDLE) begin
      bit_cnt_reg <= 5'h00;           // Ignore SI while idle
    end else if (sck_rise) begin
      case (state_reg)
        ST_OPC: begin
          opc_reg <= {opc_reg[OPC_BITS-2:0], sync_reg[PIN_SI]};
          bit_cnt_reg <= (bit_cnt_reg == 5'(OPC_BITS - 1)) ? 5'h00 :
                         bit_cnt_reg + 5'h01;
        end
        ST_ADDR: begin
          addr_reg <= {addr_reg[ADDR_BITS-2:0], sync_reg[PIN_SI]};
          bit_cnt_reg <= addr_done ? 5'h00 : bit_cnt_reg + 5'h01;
        end
        ST_DATA: begin
          rx_sh_reg <= {rx_sh_reg[6:0], sync_reg[PIN_SI]};
          bit_cnt_reg <= byte_done ? 5'h00 : bit_cnt_reg + 5'h01;
        end
        default: begin
          bit_cnt_reg <= bit_cnt_reg;
        end
      endcase
    end
  end

  // Command outputs follow the captured fields
  assign cmd_opcode = opc_reg;
  assign cmd_addr = {addr_reg[ADDR_BITS-2:0], sync_reg[PIN_SI]};
  assign cmd_valid = addr_done && !pin_rst;
  assign cmd_discard = cmd_valid && refuse;

  //////////////////////////////////////////////////////////////////////
  // Command acceptance flags
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_mode_reg <= 1'b0;
      mod_ok_reg <= 1'b0;
    end else if (pin_rst || !sel) begin
      rd_mode_reg <= 1'b0;
      mod_ok_reg <= 1'b0;
    end else if (cmd_valid) begin
      rd_mode_reg <= cmd_is_read;
      // Exempt commands still run under guard
      mod_ok_reg <= !refuse &&
                    (cmd_is_modify || cmd_is_spr_write);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Output shifting on clock fall, reloading per byte
  assign tx_load = (cmd_valid && cmd_is_read) ||
                   (rd_mode_reg && sck_fall && tx_cnt_reg == 3'h7);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_sh_reg <= 8'h00;
      tx_cnt_reg <= 3'h0;
      so_out <= 1'b0;
    end else if (tx_load && !sck_fall) begin
      tx_sh_reg <= tx_byte;
      tx_cnt_reg <= 3'h0;
    end else if (rd_mode_reg && sck_fall) begin
      so_out <= tx_sh_reg[7];
      tx_sh_reg <= tx_load ? tx_byte : {tx_sh_reg[6:0], 1'b0};
      tx_cnt_reg <= tx_cnt_reg + 3'h1;
    end
  end

  // Output driven only while selected
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      so_oe <= 1'b0;
    end else begin
      so_oe <= sel && !pin_rst;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Buffer address, wrapping at the chosen page size
  assign page_size = page_264 ? PAGE_LARGE : PAGE_SMALL;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      baddr_reg <= '0;
    end else if (cmd_valid) begin
      baddr_reg <= cmd_addr[BUF_AW-1:0];
    end else if (byte_done) begin
      baddr_reg <= (baddr_reg + 1'b1 >= page_size) ? '0 :
                   baddr_reg + 1'b1;
    end
  end

  // Received bytes enter the FIFO with their buffer address
  assign fifo_in = {baddr_reg, rx_sh_reg[6:0], sync_reg[PIN_SI]};

  sfpc_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .clear(pin_rst),
    .in_data(fifo_in),
    .in_valid(byte_done && !rd_mode_reg && !pin_rst),
    .in_ready(buf_ready),
    .out_data({rx_addr, rx_data}),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  //////////////////////////////////////////////////////////////////////
  // Self-timed program or erase cycle
  assign op_start = sel_rise && mod_ok_reg && !pin_rst;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      op_cnt_reg <= 32'h0000_0000;
    end else if (pin_rst) begin
      op_cnt_reg <= 32'h0000_0000;    // Abort timed cycle
    end else if (op_start) begin
      op_cnt_reg <= 32'(OP_LEN);
    end else if (op_cnt_reg != 32'h0000_0000) begin
      op_cnt_reg <= op_cnt_reg - 32'h0000_0001;
    end
  end

  assign busy = (op_cnt_reg != 32'h0000_0000);
  // Standby deferred while a timed cycle runs
  assign standby = !sel && !busy && !op_start;
endmodule

`default_nettype wire

// >>> verif/sfpc_host.sv
/* Host model on the serial pins, clock idle low.
   Assumes the bench calls one task at a time. */
`timescale 1ns/1ps
`default_nettype none
module sfpc_host (
  input wire logic sys_clk,
  output logic cs_n_pin,
  output logic sck_pin,
  output logic si_pin,
  input wire logic so_out,
  input wire logic so_oe
);
  // Idle levels between frames
  initial begin
    cs_n_pin = 1'h1;
    sck_pin = 1'h0;
    si_pin = 1'h0;
  end
  // Changing data line while deselected
  always @(posedge sys_clk) begin
    if (cs_n_pin)
      si_pin <= ~si_pin;
  end
  // Select edge, then settle
  task automatic sel(input logic lvl);
    @(posedge sys_clk);
    cs_n_pin <= lvl;
    repeat (6) @(posedge sys_clk);
  endtask
  // One byte each way, ph cycles per phase
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                      input int ph);
    for (int i = 7; i >= 0; i--) begin
      @(posedge sys_clk);
      if (!cs_n_pin)
        si_pin <= tx[i];
      repeat (ph - 1) @(posedge sys_clk);
      // Released line has no pull, so it reads as the inverse
      rx[i] = so_oe ? so_out : !so_out;
      sck_pin <= 1'h1;
      repeat (ph) @(posedge sys_clk);
      sck_pin <= 1'h0;
    end
  endtask
endmodule
`default_nettype wire

// >>> verif/sfpc_props.sv
/* Checker on the ports of sfpc_top.
   Assumes pins pass a two-stage synchroniser. */
`timescale 1ns/1ps
`default_nettype none
module sfpc_props #(
  parameter int OP_LEN = 20
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic cs_n_pin,
  input wire logic rst_n_pin,
  input wire logic wp_n_pin,
  input wire logic so_oe,
  input wire logic [sfpc_pkg::SECT_COUNT-1:0] prot_flags,
  input wire logic [sfpc_pkg::SECT_COUNT-1:0] sect_locked,
  input wire logic cmd_valid,
  input wire logic cmd_discard,
  input wire logic cmd_is_modify,
  input wire logic cmd_is_spr_write,
  input wire logic cmd_is_exempt,
  input wire logic op_start,
  input wire logic busy,
  input wire logic standby,
  input wire logic op_abort
);
  import sfpc_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////
  // Length of the current self-timed run
  int run_len_reg;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      run_len_reg <= 0;
    else
      run_len_reg <= busy ? run_len_reg + 1 : 0;
  end
  // Run held with standby off
  sequence s_held;
    (busy && !standby)[*8];
  endsequence
  // Guard low long enough to be seen
  sequence s_guarded;
    (!wp_n_pin)[*5];
  endsequence
  ////////////////////////////////////////////////////////////////////
  a_deselect_hiz: assert property (cs_n_pin[*6] |-> !so_oe)
    else $error("output driven while deselected");
  a_select_drive: assert property ((!cs_n_pin && rst_n_pin)[*6] |-> so_oe)
    else $error("output released while selected");
  a_start_after_rise: assert property (op_start |->
    $past(cs_n_pin, 2) && !$past(cs_n_pin, 4))
    else $error("start not tied to select rise");
  a_busy_standby: assert property (busy |-> !standby)
    else $error("standby during run");
  a_run_held: assert property (op_start |=> s_held)
    else $error("run not held after start");
  a_run_length: assert property ($fell(busy) && !op_abort |->
    run_len_reg == OP_LEN)
    else $error("run length wrong");
  a_guard_lock: assert property (s_guarded |-> sect_locked == prot_flags)
    else $error("flagged sectors not locked");
  a_guard_refuse: assert property (s_guarded ##0 (cmd_valid &&
    (cmd_is_modify || cmd_is_spr_write) && !cmd_is_exempt) |-> cmd_discard)
    else $error("guarded command not refused");
  a_discard_cause: assert property (cmd_discard |-> cmd_valid &&
    !cmd_is_exempt && (cmd_is_modify || cmd_is_spr_write))
    else $error("command refused without cause");
  a_abort_idle: assert property ((!rst_n_pin)[*5] |->
    op_abort && !busy && !so_oe)
    else $error("reset pin did not idle");
endmodule
bind sfpc_top sfpc_props #(.OP_LEN(OP_LEN)) i_sfpc_props (
  .sys_clk, .arst_n, .cs_n_pin, .rst_n_pin, .wp_n_pin, .so_oe,
  .prot_flags, .sect_locked, .cmd_valid, .cmd_discard, .cmd_is_modify,
  .cmd_is_spr_write, .cmd_is_exempt, .op_start, .busy, .standby, .op_abort
);
`default_nettype wire

// >>> verif/sfpc_top_tb_top.sv
/* Self-checking bench for sfpc_top with the host model.
   Assumes the self-timed run is shortened to 20 cycles. */
`timescale 1ns/1ps
`default_nettype none
module sfpc_top_tb_top;
  import sfpc_pkg::*;
  logic sys_clk = 1'h0;
  logic arst_n = 1'h0;
  logic wp_n_pin, rst_n_pin, page_264, sw_prot_en, rx_ready;
  logic cmd_is_modify, cmd_is_spr_write, cmd_is_exempt, cmd_is_read;
  logic [SECT_COUNT-1:0] prot_flags, sect_locked;
  logic [7:0] tx_byte, rx_data, rb;
  logic [BUF_AW-1:0] rx_addr;
  logic [OPC_BITS-1:0] cmd_opcode, opc_seen;
  logic [ADDR_BITS-1:0] cmd_addr, addr_seen;
  logic cs_n_pin, sck_pin, si_pin, so_out, so_oe, cmd_valid, cmd_discard;
  logic op_start, busy, standby, op_abort, rx_valid, buf_ready;
  int bad_count = 0, cmp_count = 0, n_cmd = 0, n_disc = 0, n_start = 0;
  int cyc = 0;
  sfpc_top #(.OP_LEN(20)) i_sfpc_top (
    .sys_clk, .arst_n, .cs_n_pin, .sck_pin, .si_pin, .so_out, .so_oe,
    .wp_n_pin, .rst_n_pin, .page_264, .prot_flags, .sw_prot_en,
    .sect_locked, .cmd_valid, .cmd_opcode, .cmd_addr, .cmd_is_modify,
    .cmd_is_spr_write, .cmd_is_exempt, .cmd_is_read, .cmd_discard,
    .op_start, .busy, .standby, .op_abort, .tx_byte, .tx_load(),
    .rx_data, .rx_addr, .rx_valid, .rx_ready, .buf_ready
  );
  sfpc_host i_sfpc_host (.sys_clk, .cs_n_pin, .sck_pin, .si_pin, .so_out,
    .so_oe);
  // Clock, 40 ns period
  always #20 sys_clk = ~sys_clk;
  // Pulse counts, command capture and hang limit
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cmd_valid) begin
      n_cmd <= n_cmd + 1;
      opc_seen <= cmd_opcode;
      addr_seen <= cmd_addr;
    end
    n_disc <= n_disc + int'(cmd_discard);
    n_start <= n_start + int'(op_start);
    if (cyc == 20000) begin
      bad_count++;
      $display("Error cycle_limit expected %0d seen %0d", 20000, cyc);
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Command classification from the user side
  task automatic kind(input logic m, input logic s, input logic e,
                      input logic r);
    @(posedge sys_clk);
    cmd_is_modify <= m;
    cmd_is_spr_write <= s;
    cmd_is_exempt <= e;
    cmd_is_read <= r;
  endtask
  // Select, opcode, three address bytes
  task automatic cmd(input logic [7:0] opc, input logic [23:0] adr);
    i_sfpc_host.sel(1'h0);
    i_sfpc_host.xfer(opc, rb, 4);
    for (int i = 2; i >= 0; i--) i_sfpc_host.xfer(adr[8*i+:8], rb, 4);
  endtask
  task automatic end_sim();
    if (bad_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  // Clocking while deselected
  task automatic t_desel();
    int c;
    c = n_cmd;
    for (int j = 0; j < 4; j++) i_sfpc_host.xfer(8'h82, rb, 4);
    @(negedge sys_clk);
    check("cmd_count", c, n_cmd);
    check("rx_valid", 0, rx_valid);
    check("so_oe", 0, so_oe);
    check("standby", 1, standby);
  endtask
  // Read frame, slow clock on the data byte
  task automatic t_read();
    int s;
    s = n_start;
    kind(1'h0, 1'h0, 1'h0, 1'h1);
    cmd(8'h0B, 24'h012345);
    i_sfpc_host.xfer(8'h00, rb, 6);
    check("read", 8'hA5, rb);
    i_sfpc_host.xfer(8'h00, rb, 6);
    @(negedge sys_clk);
    check("so_oe", 1, so_oe);
    check("opcode", 8'h0B, opc_seen);
    check("address", 24'h012345, addr_seen);
    check("read_next", 8'hA5, rb);
    i_sfpc_host.sel(1'h1);
    check("so_oe", 0, so_oe);
    check("start", s, n_start);
  endtask
  // Write past a full buffer, wrap at page end, drain during the run
  task automatic t_fill(input logic big);
    int s;
    logic [8:0] adr;
    s = n_start;
    adr = big ? 9'h107 : 9'h0FF;
    @(posedge sys_clk);
    page_264 <= big;
    kind(1'h1, 1'h0, 1'h0, 1'h0);
    cmd(8'h84, 24'(adr));
    for (int j = 0; j < 33; j++) i_sfpc_host.xfer(8'(j), rb, 4);
    check("buf_ready", 0, buf_ready);
    i_sfpc_host.sel(1'h1);
    check("start", s + 1, n_start);
    check("busy", 1, busy);
    check("standby", 0, standby);
    for (int j = 0; j < 32; j++) begin
      @(negedge sys_clk);
      check("rx_data", j, rx_data);
      check("rx_addr", (j == 0) ? adr : 9'(j - 1), rx_addr);
      @(posedge sys_clk) rx_ready <= 1'h1;
      @(posedge sys_clk) rx_ready <= 1'h0;
    end
    @(negedge sys_clk);
    check("rx_valid", 0, rx_valid);
    check("standby", 1, standby);
  endtask
  // Write guard: lock, refuse, exempt
  task automatic t_guard();
    int d;
    int s;
    @(posedge sys_clk);
    prot_flags <= 8'h5A;
    wp_n_pin <= 1'h0;
    repeat (6) @(posedge sys_clk);
    check("sect_locked", 8'h5A, sect_locked);
    for (int k = 0; k < 3; k++) begin
      d = n_disc;
      s = n_start;
      kind(k != 1, k == 1, k == 2, 1'h0);
      cmd(8'h3D, 24'h2A7F9A);
      i_sfpc_host.sel(1'h1);
      repeat (30) @(posedge sys_clk);
      check("discard", k < 2, n_disc - d);
      check("start", k == 2, n_start - s);
    end
    @(posedge sys_clk);
    wp_n_pin <= 1'h1;
    sw_prot_en <= 1'h1;
    prot_flags <= 8'hC3;
    repeat (6) @(posedge sys_clk);
    check("sw_lock", 8'hC3, sect_locked);
  endtask
  // Reset pin in mid-frame, then a fresh frame
  task automatic t_rst();
    int s;
    s = n_start;
    kind(1'h1, 1'h0, 1'h0, 1'h0);
    cmd(8'h82, 24'h000010);
    @(posedge sys_clk);
    rst_n_pin <= 1'h0;
    i_sfpc_host.sel(1'h1);
    check("op_abort", 1, op_abort);
    check("busy", 0, busy);
    @(posedge sys_clk);
    rst_n_pin <= 1'h1;
    tx_byte <= 8'h3C;
    kind(1'h0, 1'h0, 1'h0, 1'h1);
    cmd(8'h0B, 24'h00ABCD);
    i_sfpc_host.xfer(8'h00, rb, 4);
    check("read", 8'h3C, rb);
    i_sfpc_host.sel(1'h1);
    check("address", 24'h00ABCD, addr_seen);
    check("start", s, n_start);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    {wp_n_pin, rst_n_pin, page_264, sw_prot_en, rx_ready} = 5'h18;
    {cmd_is_modify, cmd_is_spr_write, cmd_is_exempt, cmd_is_read} = 4'h0;
    prot_flags = 8'h00;
    tx_byte = 8'hA5;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'h1;
    repeat (4) @(posedge sys_clk);
    t_desel();
    t_read();
    t_fill(1'h0);
    t_fill(1'h1);
    t_guard();
    t_rst();
    end_sim();
  end
endmodule
`default_nettype wire
